// ---- src/flash_command_sequencer.sv ----
// command launch, sequencing and read arbitration of the flash controller
//
// Behaviour
// - divider write sets the loaded flag
// - loaded flag reads zero until first write
// - program/erase without divider: access error, no run
// - busy: no new launch, parameter writes ignored
// - writing one clears complete flag, launches
// - complete flag low while running, results returned
// - unknown command code sets access error
// - read of busy block is illegal access
// - one array read at a time, arbitrated
// - margin reads follow restricted simultaneous rules
//
// Our own choices: the Wishbone slave port and the register offsets.
`default_nettype none
module flash_command_sequencer
  import flash_seq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        prog_rd_req,
  input  wire logic        data_rd_req,
  output logic             prog_rd_gnt,
  output logic             data_rd_gnt,
  output logic             rd_illegal,
  output logic             busy
);

  import flash_seq_pkg::*;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic        req;
  logic        wr;
  logic [7:0]  adr;
  logic [15:0] wdat16;
  logic [7:0]  wdat8;
  logic        lane0;
  logic        lane1;

  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr     = req && wb_we_i;
  assign adr    = {wb_adr_i[7:2], 2'b00};
  assign lane0  = wb_sel_i[0];
  assign lane1  = wb_sel_i[1];
  assign wdat8  = wb_dat_i[7:0];
  assign wdat16 = wb_dat_i[15:0];

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [DIV_W-1:0]    divide_ratio_field;
  logic                divider_loaded_flag;
  logic                command_complete_flag;
  logic                access_error_flag;
  logic                protection_violation_flag;
  status_t             st;
  logic [IDX_W-1:0]    parameter_index_field;
  logic [15:0]         command_parameter_regs [NWORDS];
  logic [7:0]          protect;
  logic [MARGIN_W-1:0] margin_level;

  seq_state_t          state;
  logic [CNT_W-1:0]    remaining;
  logic                active_data;
  cmd_info_t           act;
  logic                tick;

  // ----------------------------------------------------------------------
  // launch evaluation
  // ----------------------------------------------------------------------
  logic        st_wr;
  logic        launch_try;
  logic        flags_set;
  cmd_info_t   info;
  logic [7:0]  code;
  logic        err_set;
  logic        pv_set;
  logic        start;
  logic        prot_hit;

  // one driver per flag; the struct only gathers them for reading
  assign st         = '{command_complete_flag, access_error_flag,
                        protection_violation_flag};
  assign st_wr      = wr && adr == OFS_STATUS && lane0;
  assign launch_try = st_wr && wdat8[COMPLETE_BIT] && st.complete;
  assign flags_set  = st.acc_err || st.prot_viol;
  assign code       = command_parameter_regs[0][CODE_LSB +: 8];
  assign info       = decode_cmd(code);
  assign prot_hit   = protect[PROT_EN_BIT] && !info.mass
                      && command_parameter_regs[0][6:0] >= protect[6:0];

  // a refused launch leaves the complete flag high
  always_comb begin
    err_set = 1'b0;
    pv_set  = 1'b0;
    start   = 1'b0;
    if (launch_try && !flags_set) begin
      if (!info.known) begin
        err_set = 1'b1;
      end else if (info.prog_erase && !divider_loaded_flag) begin
        err_set = 1'b1;
      end else if (parameter_index_field < info.words - 3'd1) begin
        err_set = 1'b1;
      end else if (info.prog_erase && prot_hit) begin
        pv_set = 1'b1;
      end else begin
        start = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // clock divider register
  // ----------------------------------------------------------------------
  // divider writes are ignored mid-command so the running time base holds
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divide_ratio_field  <= RST_DIV;
      divider_loaded_flag <= 1'b0;
    end else if (wr && adr == OFS_CLKDIV && lane0 && st.complete) begin
      divide_ratio_field  <= wdat8[DIV_W-1:0];
      divider_loaded_flag <= 1'b1;
    end
  end

  timebase_divider #(
    .W (DIV_W)
  ) u_timebase (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (state == ST_RUN),
    .ratio (divide_ratio_field),
    .tick  (tick)
  );

  // ----------------------------------------------------------------------
  // error flags: set wins over a write-one clear
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
    end else begin
      if (err_set) begin
        access_error_flag <= 1'b1;
      end else if (st_wr && wdat8[ACC_ERR_BIT]) begin
        access_error_flag <= 1'b0;
      end
      if (pv_set) begin
        protection_violation_flag <= 1'b1;
      end else if (st_wr && wdat8[PROT_VIOL_BIT]) begin
        protection_violation_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      command_complete_flag <= 1'b1;
      remaining   <= '0;
      active_data <= 1'b0;
      act         <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            command_complete_flag <= 1'b0;
            state       <= ST_RUN;
            remaining   <= info.ticks;
            act         <= info;
            active_data <= command_parameter_regs[0][ARRAY_SEL_BIT];
          end
        end
        ST_RUN: begin
          if (tick) begin
            if (remaining <= 8'd1) begin
              command_complete_flag <= 1'b1;
              state   <= ST_IDLE;
            end else begin
              remaining <= remaining - 8'd1;
            end
          end
        end
        default: begin
          state   <= ST_IDLE;
          command_complete_flag <= 1'b1;
        end
      endcase
    end
  end

  logic done;
  assign done = state == ST_RUN && tick && remaining <= 8'd1;

  // margin level changes only when a margin command completes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      margin_level <= MARGIN_NORM;
    end else if (done && act.margin) begin
      margin_level <= command_parameter_regs[1][MARGIN_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // parameter words and index
  // ----------------------------------------------------------------------
  logic prm_wr;
  assign prm_wr = wr && adr == OFS_PARAM && st.complete;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NWORDS; i++) begin
        command_parameter_regs[i] <= '0;
      end
    end else if (done) begin
      // result: 01 for a margin command, 00 otherwise, with the level now in force
      command_parameter_regs[NWORDS-1] <=
        {act.margin ? 8'h01 : 8'h00, 6'h00,
         act.margin ? command_parameter_regs[1][MARGIN_W-1:0]
                    : margin_level};
    end else if (prm_wr && parameter_index_field < IDX_W'(NWORDS)) begin
      if (lane0) begin
        command_parameter_regs[parameter_index_field][7:0] <= wdat16[7:0];
      end
      if (lane1) begin
        command_parameter_regs[parameter_index_field][15:8] <=
          wdat16[15:8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      parameter_index_field <= RST_INDEX;
    end else if (wr && adr == OFS_INDEX && lane0 && st.complete) begin
      parameter_index_field <= wdat8[IDX_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      protect <= RST_PROTECT;
    end else if (wr && adr == OFS_PROTECT && lane0 && st.complete) begin
      protect <= wdat8;
    end
  end

  // ----------------------------------------------------------------------
  // bus answer: ack one cycle after the request, unmapped reads zero
  // ----------------------------------------------------------------------
  logic [31:0] rdat;
  logic [15:0] prm_rd;

  assign prm_rd = parameter_index_field < IDX_W'(NWORDS)
                  ? command_parameter_regs[parameter_index_field]
                  : 16'h0000;

  always_comb begin
    rdat = 32'h0000_0000;
    case (adr)
      OFS_CLKDIV: begin
        rdat[DIV_W-1:0]  = divide_ratio_field;
        rdat[LOADED_BIT] = divider_loaded_flag;
      end
      OFS_STATUS: begin
        rdat[COMPLETE_BIT]  = st.complete;
        rdat[ACC_ERR_BIT]   = st.acc_err;
        rdat[PROT_VIOL_BIT] = st.prot_viol;
      end
      OFS_INDEX:   rdat[IDX_W-1:0]    = parameter_index_field;
      OFS_PARAM:   rdat[15:0]         = prm_rd;
      OFS_PROTECT: rdat[7:0]          = protect;
      OFS_MARGIN:  rdat[MARGIN_W-1:0] = margin_level;
      default:     rdat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rdat;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read arbitration between the two arrays
  // ----------------------------------------------------------------------
  logic running;
  logic margin_on;
  logic prog_bad;
  logic data_bad;
  logic prog_ok;
  logic data_ok;
  logic prefer_data;

  assign running   = state == ST_RUN;
  assign margin_on = margin_level != MARGIN_NORM;
  // margin reads may not overlap any running algorithm
  assign prog_bad  = prog_rd_req && running
                     && (!active_data || act.mass || margin_on);
  assign data_bad  = data_rd_req && running
                     && (active_data || act.mass || margin_on);
  assign prog_ok   = prog_rd_req && !prog_bad;
  assign data_ok   = data_rd_req && !data_bad;

  // alternate on contention so neither requester starves
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prog_rd_gnt <= 1'b0;
      data_rd_gnt <= 1'b0;
      prefer_data <= 1'b0;
      rd_illegal  <= 1'b0;
    end else begin
      rd_illegal <= prog_bad || data_bad;
      if (prog_ok && data_ok) begin
        prog_rd_gnt <= !prefer_data;
        data_rd_gnt <= prefer_data;
        prefer_data <= !prefer_data;
      end else begin
        prog_rd_gnt <= prog_ok;
        data_rd_gnt <= data_ok;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= start || (running && !done);
    end
  end

endmodule
`default_nettype wire

// ---- src/flash_seq_pkg.sv ----
// shared constants, types and command decode of the flash command sequencer
`default_nettype none
package flash_seq_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CLKDIV  = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_INDEX   = 8'h08;
  localparam logic [7:0] OFS_PARAM   = 8'h0c;
  localparam logic [7:0] OFS_PROTECT = 8'h10;
  localparam logic [7:0] OFS_MARGIN  = 8'h14;

  // ----------------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------------
  localparam int unsigned DIV_W         = 7;
  localparam int unsigned LOADED_BIT    = 7;
  localparam int unsigned COMPLETE_BIT  = 7;
  localparam int unsigned ACC_ERR_BIT   = 5;
  localparam int unsigned PROT_VIOL_BIT = 4;
  localparam int unsigned IDX_W         = 3;
  localparam int unsigned NWORDS        = 6;
  localparam int unsigned PROT_EN_BIT   = 7;
  localparam int unsigned CODE_LSB      = 8;
  localparam int unsigned ARRAY_SEL_BIT = 7;
  localparam int unsigned MARGIN_W      = 2;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [DIV_W-1:0]    RST_DIV     = 7'h00;
  localparam logic [IDX_W-1:0]    RST_INDEX   = 3'h0;
  localparam logic [7:0]          RST_PROTECT = 8'h00;
  localparam logic [MARGIN_W-1:0] MARGIN_NORM = 2'h0;

  // ----------------------------------------------------------------------
  // command codes and durations in time-base ticks (about 1 us each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_PROG_P       = 8'h06;
  localparam logic [7:0] CMD_ERASE_ALL    = 8'h08;
  localparam logic [7:0] CMD_ERASE_BLOCK  = 8'h09;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h0a;
  localparam logic [7:0] CMD_USER_MARGIN  = 8'h0d;
  localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0e;
  localparam logic [7:0] CMD_PROG_D       = 8'h11;

  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] PROG_TICKS   = 8'd20;
  localparam logic [CNT_W-1:0] ERASE_TICKS  = 8'd100;
  localparam logic [CNT_W-1:0] MARGIN_TICKS = 8'd1;

  typedef enum {ST_IDLE, ST_RUN} seq_state_t;

  typedef struct packed {
    logic                 known;
    logic                 prog_erase;
    logic                 mass;
    logic                 margin;
    logic [IDX_W-1:0]     words;
    logic [CNT_W-1:0]     ticks;
  } cmd_info_t;

  typedef struct packed {
    logic complete;
    logic acc_err;
    logic prot_viol;
  } status_t;

  function automatic cmd_info_t decode_cmd(input logic [7:0] code);
    cmd_info_t c;
    c = '0;
    case (code)
      CMD_PROG_P, CMD_PROG_D: begin
        c = '{1'b1, 1'b1, 1'b0, 1'b0, 3'd3, PROG_TICKS};
      end
      CMD_ERASE_SECTOR: begin
        c = '{1'b1, 1'b1, 1'b0, 1'b0, 3'd1, ERASE_TICKS};
      end
      CMD_ERASE_ALL, CMD_ERASE_BLOCK: begin
        c = '{1'b1, 1'b1, 1'b1, 1'b0, 3'd1, ERASE_TICKS};
      end
      CMD_USER_MARGIN, CMD_FIELD_MARGIN: begin
        c = '{1'b1, 1'b0, 1'b0, 1'b1, 3'd2, MARGIN_TICKS};
      end
      default: begin
        c = '0;
      end
    endcase
    return c;
  endfunction

endpackage
`default_nettype wire

// ---- src/timebase_divider.sv ----
// divider that turns the bus clock into the program/erase time-base tick
`default_nettype none
module timebase_divider #(
  parameter int unsigned W = 7
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         run,
  input  wire logic [W-1:0] ratio,
  output logic              tick
);

  logic [W-1:0] count;

  // tick once every ratio+1 cycles; restarts when idle so timing is aligned
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count >= ratio) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- tb/flash_command_sequencer_props.sv ----
// checker of bus handshake, read arbitration and busy behaviour
`default_nettype none
module flash_seq_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic prog_rd_req,
  input wire logic data_rd_req,
  input wire logic prog_rd_gnt,
  input wire logic data_rd_gnt,
  input wire logic rd_illegal,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic req = wb_cyc_i && wb_stb_i;
  // launch edge excluded: a request there may already meet a busy block
  wire logic quiet = !busy && !req;

  AST_ACK_NEXT: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  AST_GNT_EXCL: assert property (!(prog_rd_gnt && data_rd_gnt))
    else $error("two array reads granted at once");
  AST_RD_CAUSE: assert property ((prog_rd_gnt || data_rd_gnt || rd_illegal)
    |-> $past(prog_rd_req || data_rd_req))
    else $error("read answer without request");
  AST_IDLE_GNT: assert property (quiet && prog_rd_req && !data_rd_req
    |=> prog_rd_gnt)
    else $error("idle program read not granted");
  AST_CONTEND: assert property (quiet && prog_rd_req && data_rd_req
    |=> prog_rd_gnt ^ data_rd_gnt)
    else $error("contending reads not arbitrated");
  AST_IDLE_LEGAL: assert property (quiet |=> !rd_illegal)
    else $error("illegal read flagged while idle");
  AST_BUSY_END: assert property ($rose(busy) |-> ##[1:1000] !busy)
    else $error("command never completes");

  cover property ($rose(busy));
  cover property (quiet && prog_rd_req && data_rd_req);
  cover property (rd_illegal);
endmodule

bind flash_command_sequencer flash_seq_props flash_seq_props_inst (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .prog_rd_req(prog_rd_req),
  .data_rd_req(data_rd_req), .prog_rd_gnt(prog_rd_gnt),
  .data_rd_gnt(data_rd_gnt), .rd_illegal(rd_illegal), .busy(busy));
`default_nettype wire

// ---- tb/flash_command_sequencer_test.sv ----
// self-checking bench of the flash command sequencer
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  mismatches++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module flash_command_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_seq_pkg::*;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 0, c;
  logic [3:0]  sel = 0;
  logic [31:0] dat = 0, q, rdat, r;
  logic [31:0] seed = 32'h483a;
  logic [15:0] w0;
  logic [1:0]  mlvl = 0, g;
  logic        prq = 0, drq = 0, pg, dg, ill, bsy, ack;
  int          mismatches = 0, check_count = 0, cycles = 0;

  always #2.5 clk = ~clk; // bus clock far above the lower limit

  flash_command_sequencer flash_command_sequencer_inst (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .prog_rd_req(prq),
    .data_rd_req(drq), .prog_rd_gnt(pg), .data_rd_gnt(dg),
    .rd_illegal(ill), .busy(bsy));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic summarize();
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // bus and read-port drivers
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask

  // one sampled request; answer registered one cycle later
  task automatic rt(input logic p, input logic d, input logic e);
    @(posedge clk);
    prq <= p;
    drq <= d;
    @(posedge clk);
    prq <= 0;
    drq <= 0;
    #1;
    `CHK(ill, e)
    `CHK(pg | dg, !e)
  endtask

  // index is left at 2, enough for every command
  task automatic load(input logic [7:0] cd, input logic ar,
                      input logic [1:0] lv);
    r = rnd();
    w0 = {cd, ar, r[6:0]};
    bus(1'b1, OFS_INDEX, 32'h0);
    bus(1'b1, OFS_PARAM, {16'h0, w0});
    bus(1'b1, OFS_INDEX, 32'h1);
    bus(1'b1, OFS_PARAM, {30'h0, lv});
    bus(1'b1, OFS_INDEX, 32'h2);
    bus(1'b1, OFS_PARAM, {16'h0, r[31:16]});
  endtask

  // ----------------------------------------------------------------------
  // one full command, with reads and ignored writes while it runs unless it is a margin command
  // ----------------------------------------------------------------------
  task automatic run(input logic [7:0] cd, input logic ar,
                     input logic [1:0] lv);
    logic mg, ms;
    mg = cd inside {CMD_USER_MARGIN, CMD_FIELD_MARGIN};
    ms = cd inside {CMD_ERASE_ALL, CMD_ERASE_BLOCK};
    load(cd, ar, lv);
    bus(1'b1, OFS_STATUS, 32'h80);
    // margin commands end too soon to be seen running
    if (!mg) begin
      `CHK(bsy, 1'b1)
      rchk(OFS_STATUS, 32'h0);
      rt(1'b1, 1'b0, ms || mlvl != 0 || !ar);
      rt(1'b0, 1'b1, ms || mlvl != 0 || ar);
      bus(1'b1, OFS_INDEX, 32'h0);
      bus(1'b1, OFS_PARAM, rnd());
    end
    while (bsy !== 1'b0) @(posedge clk);
    if (mg)
      mlvl = lv;
    rchk(OFS_STATUS, 32'h80);
    rchk(OFS_INDEX, 32'h2);
    rchk(OFS_MARGIN, {30'h0, mlvl});
    bus(1'b1, OFS_INDEX, 32'h5);
    rchk(OFS_PARAM, {16'h0, mg ? 8'h01 : 8'h00, 6'h0, mlvl});
    bus(1'b1, OFS_INDEX, 32'h0);
    rchk(OFS_PARAM, {16'h0, w0});
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    rchk(OFS_CLKDIV, 32'h0);
    rchk(OFS_STATUS, 32'h80);
    bus(1'b1, 8'h3c, rnd());
    rchk(8'h3c, 32'h0);
    load(CMD_PROG_P, 1'b0, 2'h0);
    bus(1'b1, OFS_STATUS, 32'h80);
    `CHK(bsy, 1'b0)
    rchk(OFS_STATUS, 32'ha0);
    bus(1'b1, OFS_CLKDIV, 32'h0);
    rchk(OFS_CLKDIV, 32'h80);
    // divider now loaded, but the stale error must still block launch
    bus(1'b1, OFS_STATUS, 32'h80);
    `CHK(bsy, 1'b0)
    rchk(OFS_STATUS, 32'ha0);
    bus(1'b1, OFS_STATUS, 32'h20);
    rchk(OFS_STATUS, 32'h80);
    // protected range and a short parameter count both refuse the launch
    bus(1'b1, OFS_PROTECT, 32'h80);
    rchk(OFS_PROTECT, 32'h80);
    load(CMD_ERASE_SECTOR, 1'b0, 2'h0);
    bus(1'b1, OFS_STATUS, 32'h80);
    `CHK(bsy, 1'b0)
    rchk(OFS_STATUS, 32'h90);
    bus(1'b1, OFS_STATUS, 32'h10);
    bus(1'b1, OFS_PROTECT, 32'h0);
    load(CMD_PROG_P, 1'b0, 2'h0);
    bus(1'b1, OFS_INDEX, 32'h1);
    bus(1'b1, OFS_STATUS, 32'h80);
    `CHK(bsy, 1'b0)
    rchk(OFS_STATUS, 32'ha0);
    bus(1'b1, OFS_STATUS, 32'h20);
    rchk(OFS_STATUS, 32'h80);
    @(posedge clk);
    prq <= 1;
    drq <= 1;
    @(posedge clk);
    #1 g = {pg, dg};
    @(posedge clk);
    prq <= 0;
    drq <= 0;
    #1;
    `CHK(g ^ {pg, dg}, 2'b11)
    // lone program read while idle is granted, never flagged
    rt(1'b1, 1'b0, 1'b0);
    rt(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      c = r[7:0];
      if (c inside {CMD_PROG_P, CMD_PROG_D, CMD_ERASE_ALL, CMD_ERASE_BLOCK,
                    CMD_ERASE_SECTOR, CMD_USER_MARGIN, CMD_FIELD_MARGIN})
        c = 8'hff;
      load(c, r[8], 2'h0);
      bus(1'b1, OFS_STATUS, 32'h80);
      rchk(OFS_STATUS, 32'ha0);
      bus(1'b1, OFS_STATUS, 32'h20);
    end
    r = rnd();
    run(CMD_USER_MARGIN, 1'b0, r[1:0] | 2'h1);
    run(CMD_PROG_P, 1'b0, 2'h0);
    run(CMD_FIELD_MARGIN, 1'b0, 2'h0);
    run(CMD_PROG_D, 1'b1, 2'h0); // data array program, run before any erase
    run(CMD_ERASE_SECTOR, 1'b0, 2'h0);
    run(CMD_ERASE_ALL, r[2], 2'h0);
    run(CMD_ERASE_BLOCK, r[3], 2'h0);
    summarize();
  end
endmodule
`default_nettype wire
